// ==== accum_timer_regs.vh ====
// Purpose: register indices, field positions and reset values of the accumulator block
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef ACCUM_TIMER_REGS_VH
`define ACCUM_TIMER_REGS_VH

// =====================================================================
// register indices
`define IDX_TIMER_CFG 6'h06
`define IDX_ACCA_CTL 6'h20
`define IDX_ACCA_FLG 6'h21
`define IDX_CNT_THREE 6'h22
`define IDX_CNT_TWO 6'h23
`define IDX_CNT_ONE 6'h24
`define IDX_CNT_ZERO 6'h25
`define IDX_MOD_CTL 6'h26
`define IDX_MOD_FLG 6'h27
`define IDX_BYTE_EN 6'h28
`define IDX_CAP_SYS 6'h2b
`define IDX_ACCB_CTL 6'h30
`define IDX_ACCB_FLG 6'h31
`define IDX_MOD_CNT 6'h36
`define IDX_HOLD 6'h38

// =====================================================================
// field positions
`define B_TIMER_EN 7
`define B_FAST_CLR 4
`define B_PA_EN 6
`define B_GATED 5
`define B_EDGE 4
`define B_CLKSEL_HI 3
`define B_CLKSEL_LO 2
`define B_A_OVF_IE 1
`define B_EDGE_IE 0
`define B_A_OVF 1
`define B_EDGE_F 0
`define B_MC_IE 7
`define B_MC_RELOAD 6
`define B_MC_RDLOAD 5
`define B_MC_LATCH 4
`define B_MC_FLOAD 3
`define B_MC_EN 2
`define B_MC_PR_HI 1
`define B_MC_PR_LO 0
`define B_MC_ZF 7
`define B_SATURATE 4
`define B_BUF_EN 1
`define B_LATCH_MODE 0
`define B_PB_EN 6
`define B_B_OVF_IE 1
`define B_B_OVF 1

// =====================================================================
// reset values and timing counts
`define RST_BYTE 8'h00
`define RST_MOD_CNT 16'hffff
`define RST_MOD_LOAD 16'h0000
`define GATE_DIV_LAST 6'h3f
`define PR_LAST_1 4'h0
`define PR_LAST_4 4'h3
`define PR_LAST_8 4'h7
`define PR_LAST_16 4'hf

`endif

// ==== pin_source.sv ====
// Purpose: drives the timer input pins for the bench
// Assumes: pins are sampled asynchronously by the block
// Notes: pulse width in clock cycles, eight low cycles after each pulse
module pin_source (
    // clock
    input logic clk,
    // pins seven down to zero
    output logic [7:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pins = 8'h00;
    task automatic pulse(input int ch, input int n, input int w);
        repeat (n) begin
            @(posedge clk);
            pins[ch] <= 1'b1;
            repeat (w) @(posedge clk);
            pins[ch] <= 1'b0;
            repeat (8) @(posedge clk);
        end
    endtask
    task automatic level(input int ch, input logic v);
        @(posedge clk);
        pins[ch] <= v;
        repeat (8) @(posedge clk);
    endtask
endmodule

// ==== pulse_accumulator_modulus_counter.v ====
// Purpose: pulse accumulators A and B plus modulus down-counter control, APB slave
// Assumes: pins asynchronous to clk; prescale_tick is a one-cycle pulse on clk
// Notes: one wait state on every APB access
// Operation
// - A enable chains bytes three and two
// - A disabled: bytes enabled individually, no edge flag
// - event mode counts selected edge of pin seven
// - gated mode counts clk/64 during gate level when timer enabled
// - two-bit field selects main counter clock
// - A disabled forces prescaler clock; selection immediate
// - A overflow and edge flags raise interrupts
// - A overflow on 16-bit or byte three wrap
// - saturated byte three plus edge sets overflow
// - edge flag on active or trailing edge
// - fast clear on count three/two access
// - B enable chains bytes one and zero
// - software write beats simultaneous increment
// - modulus interrupt only when enable set
// - one-shot stops at zero, modulus reloads
// - read select chooses count or load
// - force latch copies and clears accumulators
// - force load copies load, resets prescaler
// - disabled modulus counter held at all ones
// - prescaler 1/4/8/16, applied at next load
// - underflow flag set at zero, write-one clears
//
// The implementer's own choice: register access over APB.
`include "accum_timer_regs.vh"

module pulse_accumulator_modulus_counter (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_r,
    output reg pready_r,
    output reg pslverr_r,
    // timer pins
    input wire timer_pin_seven,
    input wire timer_pin_three,
    input wire timer_pin_two,
    input wire timer_pin_one,
    input wire timer_pin_zero,
    // rest of the timer
    input wire prescale_tick,
    output reg main_count_tick_r,
    output reg capture_latch_r,
    // interrupt requests
    output reg irq_accum_a_ovf_r,
    output reg irq_input_edge_r,
    output reg irq_accum_b_ovf_r,
    output reg irq_modulus_r
);

// =====================================================================
// functions
function [8:0] bump8;
    input [7:0] v;
    input sat;
    begin
        if (v == 8'hff && sat) begin
            bump8 = {1'b0, v};
        end else begin
            bump8 = {1'b0, v} + 9'h001;
        end
    end
endfunction

function [3:0] rate_last;
    input [1:0] sel;
    begin
        case (sel)
            2'b00: rate_last = `PR_LAST_1;
            2'b01: rate_last = `PR_LAST_4;
            2'b10: rate_last = `PR_LAST_8;
            default: rate_last = `PR_LAST_16;
        endcase
    end
endfunction

// =====================================================================
// registers
reg [7:0] timer_cfg_r, acca_ctl_r, byte_en_r, cap_sys_r, accb_ctl_r, mod_ctl_r;
reg acca_ovf_r, edge_flag_r, accb_ovf_r, mod_zf_r;
reg [7:0] acc3_r, acc2_r, acc1_r, acc0_r;
reg [31:0] hold_r;
reg [15:0] mod_cnt_r, mod_load_r;
reg [3:0] mod_presc_r, mod_rate_r;
reg [5:0] div64_r;
reg [15:0] accum_clock_div_r;
reg [4:0] pin_s1_r, pin_s2_r, pin_prev_r;

// =====================================================================
// apb decode
wire [5:0] idx = paddr[7:2];
wire acc = psel & penable & pready_r;
wire wr = acc & pwrite;
wire [7:0] wb = pwdata[7:0];
wire wr_three = wr && idx == `IDX_CNT_THREE;
wire wr_two = wr && idx == `IDX_CNT_TWO;
wire wr_one = wr && idx == `IDX_CNT_ONE;
wire wr_zero = wr && idx == `IDX_CNT_ZERO;
wire wr_mctl = wr && idx == `IDX_MOD_CTL;
wire wr_mcnt = wr && idx == `IDX_MOD_CNT;

// =====================================================================
// pin edges (second sync stage onward)
wire [4:0] rise = pin_s2_r & ~pin_prev_r;
wire [4:0] fall = ~pin_s2_r & pin_prev_r;

// =====================================================================
// control fields
wire timer_enable = timer_cfg_r[`B_TIMER_EN];
wire fast_flag_clear = timer_cfg_r[`B_FAST_CLR];
wire accum_a_system_enable = acca_ctl_r[`B_PA_EN];
wire gated_mode_select = acca_ctl_r[`B_GATED];
wire edge_level_select = acca_ctl_r[`B_EDGE];
wire [1:0] counter_clock_select = acca_ctl_r[`B_CLKSEL_HI:`B_CLKSEL_LO];
wire accum_saturate = cap_sys_r[`B_SATURATE];
wire holding_buffer_enable = cap_sys_r[`B_BUF_EN];
wire latch_or_queue_select = cap_sys_r[`B_LATCH_MODE];
wire accum_b_system_enable = accb_ctl_r[`B_PB_EN];
wire modulus_enable = mod_ctl_r[`B_MC_EN];
wire modulus_reload_mode = mod_ctl_r[`B_MC_RELOAD];

// =====================================================================
// accumulator A clock
wire div64_tick = timer_enable && div64_r == `GATE_DIV_LAST;
wire pin7_active_edge = edge_level_select ? rise[4] : fall[4];
wire gate_open = edge_level_select ? ~pin_s2_r[4] : pin_s2_r[4];
wire accum_clock = accum_a_system_enable &
    (gated_mode_select ? (div64_tick & gate_open) : pin7_active_edge);
wire edge_set = accum_a_system_enable & pin7_active_edge;

// 16-bit chains, increment skipped when either byte is written
wire [16:0] a16_inc = {1'b0, acc3_r, acc2_r} + 17'h00001;
wire [16:0] b16_inc = {1'b0, acc1_r, acc0_r} + 17'h00001;
wire a16_step = accum_clock & ~wr_three & ~wr_two;
wire b16_step = accum_b_system_enable & rise[0] & ~wr_one & ~wr_zero;

// individual byte counting while the chain is off
wire step3 = ~accum_a_system_enable & byte_en_r[3] & rise[3];
wire step2 = ~accum_a_system_enable & byte_en_r[2] & rise[2];
wire step1 = ~accum_b_system_enable & byte_en_r[1] & rise[1];
wire step0 = ~accum_b_system_enable & byte_en_r[0] & rise[0];
wire [8:0] n3 = bump8(acc3_r, accum_saturate);
wire [8:0] n2 = bump8(acc2_r, accum_saturate);
wire [8:0] n1 = bump8(acc1_r, accum_saturate);
wire [8:0] n0 = bump8(acc0_r, accum_saturate);

wire a_ovf_set = (a16_step & a16_inc[16]) | (step3 & ~wr_three & n3[8])
    | (step3 & accum_saturate && acc3_r == 8'hff);
wire b_ovf_set = (b16_step & b16_inc[16]) | (step1 & ~wr_one & n1[8]);

// =====================================================================
// modulus counter
wire mod_tick = modulus_enable && mod_presc_r == mod_rate_r;
wire force_load = wr_mctl & wb[`B_MC_FLOAD] & modulus_enable;
wire mod_load_evt = force_load | (wr_mcnt & modulus_enable);
wire mod_zero_evt = mod_tick && !mod_load_evt && mod_cnt_r == 16'h0001;
wire latch_mode = latch_or_queue_select & holding_buffer_enable;
wire latch_evt = latch_mode & ((wr_mctl & wb[`B_MC_LATCH])
    | mod_zero_evt | (wr_mcnt && pwdata[15:0] == 16'h0000));
wire cnt_a_access = acc && (idx == `IDX_CNT_THREE || idx == `IDX_CNT_TWO);
wire fast_clr_a = fast_flag_clear & cnt_a_access;
wire fast_clr_m = fast_flag_clear & acc && idx == `IDX_MOD_CNT;
wire wr_aflg = wr && idx == `IDX_ACCA_FLG;

// =====================================================================
// read mux
reg [31:0] rd_val;
reg rd_ok;
always @* begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    case (idx)
        `IDX_TIMER_CFG: rd_val[7:0] = timer_cfg_r;
        `IDX_ACCA_CTL: rd_val[7:0] = acca_ctl_r;
        `IDX_ACCA_FLG: rd_val[1:0] = {acca_ovf_r, edge_flag_r};
        `IDX_CNT_THREE: rd_val[7:0] = acc3_r;
        `IDX_CNT_TWO: rd_val[7:0] = acc2_r;
        `IDX_CNT_ONE: rd_val[7:0] = acc1_r;
        `IDX_CNT_ZERO: rd_val[7:0] = acc0_r;
        `IDX_MOD_CTL: rd_val[7:0] = mod_ctl_r & 8'he7;
        `IDX_MOD_FLG: rd_val[`B_MC_ZF] = mod_zf_r;
        `IDX_BYTE_EN: rd_val[3:0] = byte_en_r[3:0];
        `IDX_CAP_SYS: rd_val[7:0] = cap_sys_r;
        `IDX_ACCB_CTL: rd_val[7:0] = accb_ctl_r;
        `IDX_ACCB_FLG: rd_val[`B_B_OVF] = accb_ovf_r;
        `IDX_MOD_CNT: rd_val[15:0] = mod_ctl_r[`B_MC_RDLOAD] ? mod_load_r : mod_cnt_r;
        `IDX_HOLD: rd_val = hold_r;
        default: rd_ok = 1'b0;
    endcase
end

// =====================================================================
// apb handshake, pins, clock selection
always @(posedge clk) begin
    if (!rst_b) begin
        prdata_r <= 32'h00000000;
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
        pin_s1_r <= 5'h00;
        pin_s2_r <= 5'h00;
        pin_prev_r <= 5'h00;
        div64_r <= 6'h00;
        accum_clock_div_r <= 16'h0000;
        main_count_tick_r <= 1'b0;
    end else begin
        pready_r <= psel & penable & ~pready_r;
        if (psel & penable & ~pready_r) begin
            prdata_r <= pwrite ? 32'h00000000 : rd_val;
            pslverr_r <= ~rd_ok;
        end else begin
            pslverr_r <= 1'b0;
        end
        pin_s1_r <= {timer_pin_seven, timer_pin_three, timer_pin_two,
            timer_pin_one, timer_pin_zero};
        pin_s2_r <= pin_s1_r;
        pin_prev_r <= pin_s2_r;
        div64_r <= timer_enable ? div64_r + 6'h01 : 6'h00;
        if (accum_clock) begin
            accum_clock_div_r <= accum_clock_div_r + 16'h0001;
        end
        if (!accum_a_system_enable) begin
            main_count_tick_r <= prescale_tick;
        end else begin
            case (counter_clock_select)
                2'b00: main_count_tick_r <= prescale_tick;
                2'b01: main_count_tick_r <= accum_clock;
                2'b10: main_count_tick_r <= accum_clock && accum_clock_div_r[7:0] == 8'hff;
                default: main_count_tick_r <= accum_clock && accum_clock_div_r == 16'hffff;
            endcase
        end
    end
end

// =====================================================================
// control registers and flags
always @(posedge clk) begin
    if (!rst_b) begin
        timer_cfg_r <= `RST_BYTE;
        acca_ctl_r <= `RST_BYTE;
        byte_en_r <= `RST_BYTE;
        cap_sys_r <= `RST_BYTE;
        accb_ctl_r <= `RST_BYTE;
        mod_ctl_r <= `RST_BYTE;
        acca_ovf_r <= 1'b0;
        edge_flag_r <= 1'b0;
        accb_ovf_r <= 1'b0;
        mod_zf_r <= 1'b0;
        irq_accum_a_ovf_r <= 1'b0;
        irq_input_edge_r <= 1'b0;
        irq_accum_b_ovf_r <= 1'b0;
        irq_modulus_r <= 1'b0;
    end else begin
        if (wr && idx == `IDX_TIMER_CFG) timer_cfg_r <= wb & 8'h90;
        if (wr && idx == `IDX_ACCA_CTL) acca_ctl_r <= wb & 8'h7f;
        if (wr && idx == `IDX_BYTE_EN) byte_en_r <= wb & 8'h0f;
        if (wr && idx == `IDX_CAP_SYS) cap_sys_r <= wb & 8'h13;
        if (wr && idx == `IDX_ACCB_CTL) accb_ctl_r <= wb & 8'h42;
        if (wr_mctl) mod_ctl_r <= wb & 8'he7;
        // set wins over every clear
        acca_ovf_r <= a_ovf_set | (acca_ovf_r & ~fast_clr_a
            & ~(wr_aflg & wb[`B_A_OVF]));
        edge_flag_r <= edge_set | (edge_flag_r & ~fast_clr_a
            & ~(wr_aflg & wb[`B_EDGE_F]));
        accb_ovf_r <= b_ovf_set | (accb_ovf_r
            & ~(wr && idx == `IDX_ACCB_FLG && wb[`B_B_OVF]));
        mod_zf_r <= mod_zero_evt | (mod_zf_r & ~fast_clr_m
            & ~(wr && idx == `IDX_MOD_FLG && wb[`B_MC_ZF]));
        irq_accum_a_ovf_r <= acca_ovf_r & acca_ctl_r[`B_A_OVF_IE];
        irq_input_edge_r <= edge_flag_r & acca_ctl_r[`B_EDGE_IE];
        irq_accum_b_ovf_r <= accb_ovf_r & accb_ctl_r[`B_B_OVF_IE];
        irq_modulus_r <= mod_zf_r & mod_ctl_r[`B_MC_IE];
    end
end

// =====================================================================
// accumulator bytes and holding register
always @(posedge clk) begin
    if (!rst_b) begin
        acc3_r <= `RST_BYTE;
        acc2_r <= `RST_BYTE;
        acc1_r <= `RST_BYTE;
        acc0_r <= `RST_BYTE;
        hold_r <= 32'h00000000;
        capture_latch_r <= 1'b0;
    end else begin
        if (a16_step) begin
            {acc3_r, acc2_r} <= a16_inc[15:0];
        end else begin
            if (step3) acc3_r <= n3[7:0];
            if (step2) acc2_r <= n2[7:0];
        end
        if (b16_step) begin
            {acc1_r, acc0_r} <= b16_inc[15:0];
        end else begin
            if (step1) acc1_r <= n1[7:0];
            if (step0) acc0_r <= n0[7:0];
        end
        capture_latch_r <= latch_evt;
        if (latch_evt) begin
            hold_r <= {acc3_r, acc2_r, acc1_r, acc0_r};
            acc3_r <= `RST_BYTE;
            acc2_r <= `RST_BYTE;
            acc1_r <= `RST_BYTE;
            acc0_r <= `RST_BYTE;
        end
        // software write last so it wins
        if (wr_three) acc3_r <= wb;
        if (wr_two) acc2_r <= wb;
        if (wr_one) acc1_r <= wb;
        if (wr_zero) acc0_r <= wb;
    end
end

// =====================================================================
// modulus down-counter
always @(posedge clk) begin
    if (!rst_b) begin
        mod_cnt_r <= `RST_MOD_CNT;
        mod_load_r <= `RST_MOD_LOAD;
        mod_presc_r <= 4'h0;
        mod_rate_r <= `PR_LAST_1;
    end else begin
        if (wr_mcnt) begin
            mod_load_r <= pwdata[15:0];
        end
        if (!modulus_enable) begin
            mod_cnt_r <= `RST_MOD_CNT;
            mod_presc_r <= 4'h0;
        end else if (mod_load_evt) begin
            mod_cnt_r <= wr_mcnt ? pwdata[15:0] : mod_load_r;
            mod_presc_r <= 4'h0;
            mod_rate_r <= rate_last(mod_ctl_r[`B_MC_PR_HI:`B_MC_PR_LO]);
        end else if (mod_tick) begin
            mod_presc_r <= 4'h0;
            if (mod_zero_evt && modulus_reload_mode) begin
                mod_cnt_r <= mod_load_r;
                mod_rate_r <= rate_last(mod_ctl_r[`B_MC_PR_HI:`B_MC_PR_LO]);
            end else if (mod_cnt_r != 16'h0000) begin
                mod_cnt_r <= mod_cnt_r - 16'h0001;
            end
        end else begin
            mod_presc_r <= mod_presc_r + 4'h1;
        end
    end
end

endmodule

// ==== pulse_accumulator_modulus_counter_assertions.sv ====
// Purpose: port-level checks of the accumulator and modulus block
// Assumes: one clock, synchronous active-low reset
// Notes: control bits are shadowed from completed apb writes
`include "accum_timer_regs.vh"
module pulse_accumulator_modulus_counter_assertions (
    // clock and reset
    input logic clk,
    input logic rst_b,
    // apb
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata_r,
    input logic pready_r,
    input logic pslverr_r,
    // timer links
    input logic prescale_tick,
    input logic main_count_tick_r,
    input logic irq_accum_a_ovf_r,
    input logic irq_input_edge_r,
    input logic irq_modulus_r
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] acca_r;
    logic mc_ie_r;
    logic use_pre;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // =====================================================
    // control shadows
    always @(posedge clk) begin
        if (!rst_b) begin
            acca_r <= 8'h00;
            mc_ie_r <= 1'b0;
        end else if (psel && penable && pready_r && pwrite && !pslverr_r) begin
            if (paddr[7:2] == `IDX_ACCA_CTL) begin
                acca_r <= pwdata[7:0];
            end
            if (paddr[7:2] == `IDX_MOD_CTL) begin
                mc_ie_r <= pwdata[`B_MC_IE];
            end
        end
    end
    assign use_pre = !acca_r[`B_PA_EN] || (acca_r[3:2] == 2'b00);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    // =====================================================
    // assertions
    chk_ready_pulse: assert property (pready_r |=> !pready_r)
        else $error("ready held beyond one cycle");
    chk_one_wait: assert property (setup_s ##1 access_s |-> !pready_r ##1 pready_r)
        else $error("access phase not two cycles");
    chk_err_ready: assert property (pslverr_r |-> pready_r)
        else $error("error response without ready");
    chk_unmapped_zero: assert property (pready_r && pslverr_r && !pwrite |-> prdata_r == 32'h0)
        else $error("refused read returned data");
    chk_force_bits:
        assert property (pready_r && !pwrite && paddr[7:2] == `IDX_MOD_CTL
            |-> prdata_r[4:3] == 2'b00) else $error("force bits read back set");
    chk_mod_irq_gate:
        assert property (!mc_ie_r && !$past(mc_ie_r) |-> !irq_modulus_r)
        else $error("modulus request while disabled");
    chk_aovf_gate:
        assert property (!acca_r[1] && !$past(acca_r[1]) |-> !irq_accum_a_ovf_r)
        else $error("overflow request while disabled");
    chk_edge_gate:
        assert property (!acca_r[0] && !$past(acca_r[0]) |-> !irq_input_edge_r)
        else $error("edge request while disabled");
    chk_prescale_path:
        assert property (use_pre && $past(use_pre) && $past(rst_b)
            |-> main_count_tick_r == $past(prescale_tick))
        else $error("main tick not following prescaler");
endmodule

// ==== pulse_accumulator_modulus_counter_tb.sv ====
// Purpose: self-checking bench for the accumulator and modulus block
// Assumes: pins come from pin_source, apb answers after one wait state
// Notes: reads queue their expectation, a monitor compares on completion
`include "accum_timer_regs.vh"
module pulse_accumulator_modulus_counter_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_b, pwrite;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic prescale_tick = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] seed = 32'h88ae72b1;
    wire [31:0] prdata_r;
    wire pready_r, pslverr_r, main_count_tick_r, capture_latch_r;
    wire irq_accum_a_ovf_r, irq_input_edge_r, irq_accum_b_ovf_r, irq_modulus_r;
    wire [7:0] pins;
    logic [64:0] expq[$];
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    int ticks = 0;
    int n_latch = 0;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    pulse_accumulator_modulus_counter DUT (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
        .timer_pin_seven(pins[7]), .timer_pin_three(pins[3]), .timer_pin_two(pins[2]),
        .timer_pin_one(pins[1]), .timer_pin_zero(pins[0]), .prescale_tick(prescale_tick),
        .main_count_tick_r(main_count_tick_r), .capture_latch_r(capture_latch_r),
        .irq_accum_a_ovf_r(irq_accum_a_ovf_r), .irq_input_edge_r(irq_input_edge_r),
        .irq_accum_b_ovf_r(irq_accum_b_ovf_r), .irq_modulus_r(irq_modulus_r));
    pin_source src (.clk(clk), .pins(pins));
    // =====================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        compares++;
        if (seen !== want) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [5:0] ix, input logic [31:0] d);
        int g;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        g = 0;
        do begin
            @(posedge clk);
            g++;
        end while (pready_r !== 1'b1 && g < 20);
        if (g >= 20) n_mismatch++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] ix, input logic [31:0] d);
        xfer(1'b1, ix, d);
    endtask
    task automatic rd(input logic [5:0] ix, input logic [31:0] e,
        input logic [31:0] m = 32'hff, input logic er = 1'b0);
        expq.push_back({er, m, e});
        xfer(1'b0, ix, 32'h0);
    endtask
    // =====================================================
    // random prescaler ticks, read monitor, cycle ceiling
    always @(posedge clk) begin
        logic [64:0] e;
        seed <= xs(seed);
        prescale_tick <= rst_b && !prescale_tick && seed[1:0] == 2'b00;
        cyc++;
        if (main_count_tick_r === 1'b1) ticks++;
        if (capture_latch_r === 1'b1) n_latch++;
        if (psel && penable && pready_r === 1'b1 && !pwrite) begin
            e = expq.pop_front();
            check({pslverr_r, prdata_r & e[63:32]}, {e[64], e[31:0] & e[63:32]});
        end
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // =====================================================
    // main sequence
    initial begin
        logic [31:0] r;
        rst_b = 1'b0;
        pwrite = 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd(`IDX_MOD_CNT, 32'hffff, 32'hffff);
        rd(6'h3f, 32'h0, 32'hffffffff, 1'b1);
        wr(`IDX_ACCA_CTL, 32'h53);
        src.pulse(7, 3, 4);
        rd(`IDX_CNT_TWO, 32'h03);
        rd(`IDX_CNT_THREE, 32'h00);
        rd(`IDX_ACCA_FLG, 32'h01);
        check({32'h0, irq_input_edge_r}, 33'h1);
        wr(`IDX_ACCA_CTL, 32'h43);
        src.level(7, 1'b1);
        rd(`IDX_CNT_TWO, 32'h03);
        src.level(7, 1'b0);
        rd(`IDX_CNT_TWO, 32'h04);
        wr(`IDX_ACCA_FLG, 32'h03);
        wr(`IDX_CNT_THREE, 32'hff);
        wr(`IDX_CNT_TWO, 32'hff);
        src.pulse(7, 1, 4);
        rd(`IDX_CNT_THREE, 32'h00);
        rd(`IDX_ACCA_FLG, 32'h03);
        check({32'h0, irq_accum_a_ovf_r}, 33'h1);
        wr(`IDX_ACCA_FLG, 32'h02);
        rd(`IDX_ACCA_FLG, 32'h01);
        wr(`IDX_TIMER_CFG, 32'h10);
        src.pulse(7, 1, 4);
        rd(`IDX_CNT_TWO, 32'h01);
        rd(`IDX_ACCA_FLG, 32'h00);
        // falling edge arrives at the very edge the write lands, so the write wins and the edge is not counted
        src.level(7, 1'b1);
        fork
            src.level(7, 1'b0);
            wr(`IDX_CNT_TWO, 32'h50);
        join
        rd(`IDX_CNT_TWO, 32'h50);
        wr(`IDX_ACCA_CTL, 32'h44);
        repeat (2) @(negedge clk);
        r = 32'(ticks);
        src.pulse(7, 4, 4);
        check({1'b0, 32'(ticks) - r}, 33'd4);
        wr(`IDX_ACCA_CTL, 32'h48);
        r = 32'(ticks);
        src.pulse(7, 256, 1);
        check({1'b0, 32'(ticks) - r}, 33'd1);
        for (int t = 0; t < 2; t++) begin
            wr(`IDX_TIMER_CFG, t ? 32'h80 : 32'h00);
            wr(`IDX_ACCA_CTL, 32'h60);
            wr(`IDX_CNT_TWO, 32'h00);
            wr(`IDX_ACCA_FLG, 32'h03);
            src.pulse(7, 1, 768);
            rd(`IDX_CNT_TWO, t ? 32'h08 : 32'h00, 32'hf8);
            rd(`IDX_ACCA_FLG, 32'h01, 32'h01);
        end
        wr(`IDX_ACCA_CTL, 32'h00);
        wr(`IDX_ACCA_FLG, 32'h03);
        wr(`IDX_CNT_TWO, 32'h00);
        wr(`IDX_BYTE_EN, 32'h04);
        src.pulse(7, 2, 4);
        rd(`IDX_ACCA_FLG, 32'h00);
        src.pulse(2, 2, 4);
        rd(`IDX_CNT_TWO, 32'h02);
        wr(`IDX_CAP_SYS, 32'h10);
        wr(`IDX_BYTE_EN, 32'h08);
        wr(`IDX_CNT_THREE, 32'hff);
        src.pulse(3, 1, 4);
        rd(`IDX_CNT_THREE, 32'hff);
        rd(`IDX_ACCA_FLG, 32'h02);
        wr(`IDX_ACCB_CTL, 32'h42);
        wr(`IDX_CNT_ONE, 32'hff);
        wr(`IDX_CNT_ZERO, 32'hff);
        src.pulse(0, 1, 4);
        rd(`IDX_CNT_ONE, 32'h00);
        rd(`IDX_ACCB_FLG, 32'h02);
        check({32'h0, irq_accum_b_ovf_r}, 33'h1);
        wr(`IDX_ACCB_CTL, 32'h00);
        r = seed;
        wr(`IDX_CNT_ONE, {24'h0, r[7:0]});
        rd(`IDX_CNT_ONE, {24'h0, r[7:0]});
        wr(`IDX_CAP_SYS, 32'h03);
        wr(`IDX_CNT_THREE, 32'h11);
        wr(`IDX_CNT_TWO, 32'h22);
        wr(`IDX_CNT_ONE, 32'h33);
        wr(`IDX_CNT_ZERO, 32'h44);
        wr(`IDX_MOD_CTL, 32'h10);
        rd(`IDX_HOLD, 32'h11223344, 32'hffffffff);
        check({1'b0, 32'(n_latch)}, 33'd1);
        rd(`IDX_CNT_TWO, 32'h00);
        wr(`IDX_CAP_SYS, 32'h00);
        wr(`IDX_MOD_CNT, 32'h7);
        rd(`IDX_MOD_CNT, 32'hffff, 32'hffff);
        wr(`IDX_MOD_CTL, 32'h20);
        rd(`IDX_MOD_CNT, 32'h7, 32'hffff);
        wr(`IDX_MOD_CTL, 32'h84);
        wr(`IDX_MOD_CNT, 32'h20);
        repeat (60) @(posedge clk);
        rd(`IDX_MOD_CNT, 32'h0, 32'hffff);
        rd(`IDX_MOD_FLG, 32'h80);
        check({32'h0, irq_modulus_r}, 33'h1);
        wr(`IDX_MOD_FLG, 32'h00);
        rd(`IDX_MOD_FLG, 32'h80);
        wr(`IDX_MOD_FLG, 32'h80);
        rd(`IDX_MOD_FLG, 32'h00);
        wr(`IDX_MOD_CTL, 32'h85);
        wr(`IDX_MOD_CNT, 32'h10);
        wr(`IDX_MOD_CTL, 32'h87);
        repeat (36) @(posedge clk);
        rd(`IDX_MOD_FLG, 32'h00);
        repeat (40) @(posedge clk);
        rd(`IDX_MOD_FLG, 32'h80);
        wr(`IDX_MOD_CTL, 32'h00);
        wr(`IDX_MOD_CTL, 32'h43);
        wr(`IDX_MOD_CTL, 32'h47);
        wr(`IDX_MOD_CNT, 32'h30);
        wr(`IDX_MOD_FLG, 32'h80);
        repeat (800) @(posedge clk);
        rd(`IDX_MOD_CNT, 32'h20, 32'hfff0);
        wr(`IDX_MOD_CTL, 32'h4f);
        rd(`IDX_MOD_CNT, 32'h30, 32'hffff);
        rd(`IDX_MOD_CTL, 32'h47);
        tally_and_finish();
    end
endmodule
bind pulse_accumulator_modulus_counter pulse_accumulator_modulus_counter_assertions chk (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
    .pslverr_r(pslverr_r), .prescale_tick(prescale_tick),
    .main_count_tick_r(main_count_tick_r), .irq_accum_a_ovf_r(irq_accum_a_ovf_r),
    .irq_input_edge_r(irq_input_edge_r), .irq_modulus_r(irq_modulus_r));
